//--- hdl/smi_defines.svh
`ifndef SMI_DEFINES_SVH
`define SMI_DEFINES_SVH
// ----------------------------------------
// Register offsets on the configuration port
// ----------------------------------------
`define SMI_OFS_CFG0      5'h00
`define SMI_OFS_CFG1      5'h04
`define SMI_OFS_RSV0      5'h08
`define SMI_OFS_RSV1      5'h0C
`define SMI_OFS_BASE1     5'h10
// ----------------------------------------
// Reset values and field masks
// ----------------------------------------
`define SMI_CFG0_RST      16'h7F3D
`define SMI_CFG1_RST      16'h0001
`define SMI_BASE1_RST     16'h0000
`define SMI_CFG_WMASK     16'h7FFC
`define SMI_CFG_FIXED     16'h0001
`define SMI_BASE_WMASK    16'h0FFF
`define SMI_RSV_READ      16'h0001
// ----------------------------------------
// Field positions
// ----------------------------------------
`define SMI_RDY_TERM_BIT  7
`define SMI_ISYN_BIT      6
`define SMI_BE_BIT        5
`define SMI_WAIT_HI       4
`define SMI_WAIT_LO       2
`define SMI_LEN_HI        14
`define SMI_LEN_LO        8
`define SMI_BASE_HI       11
`define SMI_ADDR_TOP      22
`define SMI_LEN_SHIFT     16
`define SMI_BASE_ZEROS    11'h000
// ----------------------------------------
// Bus codes
// ----------------------------------------
`define SMI_SIZE_BYTE     3'h0
`define SMI_SIZE_WORD     3'h2
`define SMI_HRESP_OKAY    2'h0
`define SMI_HRESP_ERROR   2'h1
`define SMI_CNT_ZERO      4'h0
`define SMI_CNT_ONE       4'h1
`endif

//--- hdl/smi_pkg.sv
package smi_pkg;
  // Transfer sequencer states
  typedef enum logic [2:0] {
    SMI_IDLE,
    SMI_START,
    SMI_ACCESS,
    SMI_HOLD,
    SMI_ERR1,
    SMI_ERR2
  } smi_state_type;
endpackage

//--- hdl/smi_sync2.sv
`timescale 1ns/100ps
`default_nettype none
// Two-stage synchroniser for an asynchronous level
module smi_sync2 (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic d,
  output logic      q
);
  logic meta_q;
  logic sync_q;

  // First stage feeds only the second
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;
endmodule
`default_nettype wire

//--- hdl/smi_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "smi_defines.svh"
module smi_top (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready_in,
  output logic             hready_out,
  output logic [1:0]       hresp,
  output logic [31:0]      hrdata,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [4:0]  paddr,
  input  wire logic [15:0] pwdata,
  output logic [15:0]      prdata,
  output logic [21:0]      ext_addr,
  output logic [15:0]      ext_data_out,
  output logic             ext_data_oe,
  input  wire logic [15:0] ext_data_in,
  output logic             ext_read_strobe_n,
  output logic [1:0]       ext_byte_write_strobe_n,
  output logic             region0_select_n,
  output logic             region1_select_n,
  input  wire logic        ext_ready,
  input  wire logic        region1_pin_enable
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  smi_pkg::smi_state_type state_q, state_d;
  logic [15:0] cfg0_q, cfg1_q, base1_q;
  logic [15:0] prdata_q;
  logic [31:0] hrdata_q, wdata_q;
  logic [21:0] ext_addr_q;
  logic [15:0] ext_dout_q;
  logic [15:0] low_half_q;
  logic [3:0]  cnt_q;
  logic        region_q, write_q, wide_q, half_q, byte_q, lane_q;
  logic        rdy_term_q, isyn_q;
  logic [2:0]  wait_q;
  logic        ready_sync;

  // ----------------------------------------
  // Configuration port
  // ----------------------------------------
  // APB strobes and read mux
  wire        apb_wr    = psel & penable & pwrite;
  wire        apb_setup = psel & ~penable & ~pwrite;
  wire [15:0] cfg_wval  = (pwdata & `SMI_CFG_WMASK) | `SMI_CFG_FIXED;
  wire [15:0] apb_rval  =
    (paddr == `SMI_OFS_CFG0)  ? cfg0_q :
    (paddr == `SMI_OFS_CFG1)  ? cfg1_q :
    (paddr == `SMI_OFS_RSV0)  ? `SMI_RSV_READ :
    (paddr == `SMI_OFS_RSV1)  ? `SMI_RSV_READ :
    (paddr == `SMI_OFS_BASE1) ? base1_q : 16'h0000;

  // Register writes and read capture
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cfg0_q   <= `SMI_CFG0_RST;
      cfg1_q   <= `SMI_CFG1_RST;
      base1_q  <= `SMI_BASE1_RST;
      prdata_q <= 16'h0000;
    end else begin
      if (apb_wr && paddr == `SMI_OFS_CFG0) cfg0_q <= cfg_wval;
      if (apb_wr && paddr == `SMI_OFS_CFG1) cfg1_q <= cfg_wval;
      if (apb_wr && paddr == `SMI_OFS_BASE1) base1_q <= pwdata & `SMI_BASE_WMASK;
      if (apb_setup) prdata_q <= apb_rval;
    end
  end

  assign prdata = prdata_q;

  // ----------------------------------------
  // Region decode
  // ----------------------------------------
  // Region 0 from zero, region 1 from base field, 64 kB length steps
  wire [22:0] a23       = haddr[`SMI_ADDR_TOP:0];
  wire [22:0] base1_full = {base1_q[`SMI_BASE_HI:0], `SMI_BASE_ZEROS};
  wire [23:0] off1      = {1'b0, a23} - {1'b0, base1_full};
  wire [6:0]  len0      = cfg0_q[`SMI_LEN_HI:`SMI_LEN_LO];
  wire [6:0]  len1      = cfg1_q[`SMI_LEN_HI:`SMI_LEN_LO];
  wire        hit0      = cfg0_q[`SMI_BE_BIT] & (a23[22:`SMI_LEN_SHIFT] <= len0);
  wire        hit1      = cfg1_q[`SMI_BE_BIT] & region1_pin_enable & ~off1[23]
                          & (off1[22:`SMI_LEN_SHIFT] <= len1);
  wire        take      = hsel & htrans[1] & hready_in & (state_q == smi_pkg::SMI_IDLE);
  wire        sel1      = ~hit0 & hit1;
  wire [15:0] sel_cfg   = sel1 ? cfg1_q : cfg0_q;
  wire        is_wide   = (hsize == `SMI_SIZE_WORD);
  wire        is_byte   = (hsize == `SMI_SIZE_BYTE);

  // ----------------------------------------
  // Ready termination
  // ----------------------------------------
  smi_sync2 u_ready_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .d       (ext_ready),
    .q       (ready_sync)
  );

  // Ready seen through synchroniser or straight from the pin
  wire ready_in_use = isyn_q ? ready_sync : ext_ready;
  wire ready_ok     = ~rdy_term_q | ready_in_use;

  // ----------------------------------------
  // Cycle timing
  // ----------------------------------------
  // Wait count sets strobe length; reads end at wait+1, writes at wait
  wire [3:0] wait_ext  = {1'b0, wait_q};
  wire [3:0] wait_p1   = wait_ext + `SMI_CNT_ONE;
  wire       rd_end    = ~write_q & (cnt_q >= wait_p1) & ready_ok;
  wire       wr_end    = write_q & (cnt_q >= wait_ext) & ready_ok;
  wire       hi_sample = half_q & (rdy_term_q ? rd_end : (cnt_q == wait_ext));
  wire       lo_sample = ~half_q & rd_end;
  wire       more_half = wide_q & ~half_q;
  wire       selected  = (state_q == smi_pkg::SMI_ACCESS) | (state_q == smi_pkg::SMI_HOLD);

  // Next state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      smi_pkg::SMI_IDLE: begin
        if (take) begin
          state_d = (hit0 | hit1) ? smi_pkg::SMI_START : smi_pkg::SMI_ERR1;
        end
      end
      smi_pkg::SMI_START: begin
        state_d = smi_pkg::SMI_ACCESS;
      end
      smi_pkg::SMI_ACCESS: begin
        if (wr_end) begin
          state_d = smi_pkg::SMI_HOLD;
        end else if (rd_end) begin
          state_d = more_half ? smi_pkg::SMI_ACCESS : smi_pkg::SMI_IDLE;
        end
      end
      smi_pkg::SMI_HOLD: begin
        state_d = more_half ? smi_pkg::SMI_ACCESS : smi_pkg::SMI_IDLE;
      end
      smi_pkg::SMI_ERR1: begin
        state_d = smi_pkg::SMI_ERR2;
      end
      smi_pkg::SMI_ERR2: begin
        state_d = smi_pkg::SMI_IDLE;
      end
      default: begin
        state_d = smi_pkg::SMI_IDLE;
      end
    endcase
  end

  // Half switch and counter restart between the halves
  wire half_next = selected & (rd_end | (state_q == smi_pkg::SMI_HOLD)) & more_half;

  // State register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_q <= smi_pkg::SMI_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Request capture
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      region_q <= 1'b0;
      write_q  <= 1'b0;
      wide_q   <= 1'b0;
      byte_q   <= 1'b0;
      lane_q   <= 1'b0;
      rdy_term_q <= 1'b0;
      isyn_q   <= 1'b0;
      wait_q   <= 3'h0;
    end else if (take) begin
      region_q <= sel1;
      write_q  <= hwrite;
      wide_q   <= is_wide;
      byte_q   <= is_byte;
      lane_q   <= haddr[0];
      rdy_term_q <= sel_cfg[`SMI_RDY_TERM_BIT];
      isyn_q   <= sel_cfg[`SMI_ISYN_BIT];
      wait_q   <= sel_cfg[`SMI_WAIT_HI:`SMI_WAIT_LO];
    end
  end

  // Cycle counter and half tracking
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cnt_q  <= `SMI_CNT_ZERO;
      half_q <= 1'b0;
    end else if (take | half_next) begin
      cnt_q  <= `SMI_CNT_ZERO;
      half_q <= half_next;
    end else if (state_q == smi_pkg::SMI_ACCESS && cnt_q < wait_p1) begin
      cnt_q  <= cnt_q + `SMI_CNT_ONE;
    end
  end

  // ----------------------------------------
  // External address and data
  // ----------------------------------------
  // Half-word address; bit 0 from AHB bit 1 or from the half
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ext_addr_q <= 22'h00_0000;
    end else if (take) begin
      ext_addr_q <= {a23[22:2], is_wide ? 1'b0 : haddr[1]};
    end else if (half_next) begin
      ext_addr_q[0] <= 1'b1;
    end
  end

  // Write data taken in data phase, half chosen per cycle
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wdata_q    <= 32'h0000_0000;
      ext_dout_q <= 16'h0000;
    end else if (state_q == smi_pkg::SMI_START) begin
      wdata_q    <= hwdata;
      ext_dout_q <= ext_addr_q[0] ? hwdata[31:16] : hwdata[15:0];
    end else if (half_next) begin
      ext_dout_q <= wdata_q[31:16];
    end
  end

  // Read data: low half latched, word assembled on last sample
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      low_half_q <= 16'h0000;
      hrdata_q   <= 32'h0000_0000;
    end else if (state_q == smi_pkg::SMI_ACCESS && !write_q) begin
      if (lo_sample && wide_q) begin
        low_half_q <= ext_data_in;
      end else if (hi_sample) begin
        hrdata_q <= {ext_data_in, low_half_q};
      end else if (lo_sample) begin
        hrdata_q <= {ext_data_in, ext_data_in};
      end
    end
  end

  // ----------------------------------------
  // Pin drive
  // ----------------------------------------
  // Strobes and selects decoded from the sequencer
  wire we_on  = (state_q == smi_pkg::SMI_ACCESS) & write_q;
  wire we_lo  = we_on & (~byte_q | ~lane_q);
  wire we_hi  = we_on & (~byte_q | lane_q);

  assign ext_addr                = ext_addr_q;
  assign ext_data_out            = ext_dout_q;
  assign ext_data_oe             = selected & write_q;
  assign ext_read_strobe_n       = ~((state_q == smi_pkg::SMI_ACCESS) & ~write_q);
  assign ext_byte_write_strobe_n = {~we_hi, ~we_lo};
  assign region0_select_n        = ~(selected & ~region_q);
  assign region1_select_n        = ~(selected & region_q & region1_pin_enable);
  assign hready_out              = (state_q == smi_pkg::SMI_IDLE) | (state_q == smi_pkg::SMI_ERR2);
  assign hresp                   = ((state_q == smi_pkg::SMI_ERR1) | (state_q == smi_pkg::SMI_ERR2))
                                   ? `SMI_HRESP_ERROR : `SMI_HRESP_OKAY;
  assign hrdata                  = hrdata_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  cs_exclusive_a: assert property (
    @(posedge clk_sys) disable iff (rst) !(!region0_select_n && !region1_select_n))
    else $error("both region selects low");

  read_one_strobe_a: assert property (
    @(posedge clk_sys) disable iff (rst) !ext_read_strobe_n |-> (&ext_byte_write_strobe_n))
    else $error("write strobe during read");

  err_no_cycle_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    (state_q == smi_pkg::SMI_ERR1) |-> region0_select_n && region1_select_n
      && hresp == `SMI_HRESP_ERROR && !hready_out ##1 hready_out && hresp == `SMI_HRESP_ERROR)
    else $error("error response malformed");

  cs1_pin_a: assert property (
    @(posedge clk_sys) disable iff (rst) !region1_select_n |-> region1_pin_enable)
    else $error("region 1 select without pin");

  write_hold_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    $rose(&ext_byte_write_strobe_n) && !(region0_select_n && region1_select_n)
      |-> $past(!region0_select_n || !region1_select_n) && !ext_data_oe == 1'b0)
    else $error("write hold cycle missing");

  byte_write_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    we_on && byte_q |-> ext_byte_write_strobe_n == {~lane_q, lane_q})
    else $error("byte strobe lane wrong");

  split_addr_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    (state_q == smi_pkg::SMI_ACCESS) && wide_q |-> ext_addr[0] == half_q)
    else $error("split half address wrong");

  read_min_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    $fell(ext_read_strobe_n) |-> !ext_read_strobe_n [*2])
    else $error("read strobe shorter than two");

  cs_cont_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    half_next |=> !(region0_select_n && region1_select_n))
    else $error("select dropped between halves");
endmodule
`default_nettype wire

//--- bench/smi_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
// Asynchronous half-word memory seen through the external bus
module smi_mem_model (
  input  wire logic        clk_sys,
  input  wire logic [21:0] ext_addr,
  input  wire logic [15:0] ext_data_out,
  input  wire logic        ext_read_strobe_n,
  input  wire logic [1:0]  ext_byte_write_strobe_n,
  input  wire logic        select_n,
  output logic [15:0]      ext_data_in
);
  logic [15:0] mem [256];
  logic [15:0] churn_q = 16'h1234;
  // Byte lanes written while selected; idle bus churns every cycle
  always @(posedge clk_sys) begin
    churn_q <= churn_q + 16'h3A5B;
    if (!select_n && !ext_byte_write_strobe_n[0]) mem[ext_addr[7:0]][7:0] <= ext_data_out[7:0];
    if (!select_n && !ext_byte_write_strobe_n[1]) mem[ext_addr[7:0]][15:8] <= ext_data_out[15:8];
  end
  // Output follows the address while selected with read strobe low, otherwise churn value; no latching on select
  assign ext_data_in = (!select_n && !ext_read_strobe_n) ? mem[ext_addr[7:0]] : churn_q;
endmodule
`default_nettype wire

//--- bench/ahb_static_memory_interface_bench.sv
`timescale 1ns/100ps
`default_nettype none
`include "smi_defines.svh"
module ahb_static_memory_interface_bench;
  logic        clk_sys, rst, hsel, hwrite, hready_in, hready_out, psel, penable, pwrite;
  logic        ext_ready, pin_en, oe, rd_n, sel0_n, sel1_n;
  logic [31:0] haddr, hwdata, hrdata, rdat;
  logic [1:0]  htrans, hresp, bws_n, resp;
  logic [2:0]  hsize;
  logic [4:0]  paddr;
  logic [15:0] pwdata, prdata, ext_dout, ext_din;
  logic [21:0] ext_addr, first_addr;
  int          num_errors, comparisons, ncs, nc1, nrd, nw0, nw1, noe, rdy_after;

  smi_top u_smi_top (
    .clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready_in(hready_in), .hready_out(hready_out), .hresp(hresp),
    .hrdata(hrdata), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .ext_addr(ext_addr), .ext_data_out(ext_dout),
    .ext_data_oe(oe), .ext_data_in(ext_din), .ext_read_strobe_n(rd_n),
    .ext_byte_write_strobe_n(bws_n), .region0_select_n(sel0_n), .region1_select_n(sel1_n),
    .ext_ready(ext_ready), .region1_pin_enable(pin_en));

  smi_mem_model u_smi_mem_model (
    .clk_sys(clk_sys), .ext_addr(ext_addr), .ext_data_out(ext_dout), .ext_read_strobe_n(rd_n),
    .ext_byte_write_strobe_n(bws_n), .select_n(sel0_n & sel1_n), .ext_data_in(ext_din));

  // 40 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    if (num_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // One configuration port transfer, setup then access phase
  task automatic apb(input logic wr, input logic [4:0] a, input logic [15:0] d);
    @(negedge clk_sys);
    psel = 1'b1; penable = 1'b0; pwrite = wr; paddr = a; pwdata = d;
    @(negedge clk_sys);
    penable = 1'b1;
    @(negedge clk_sys);
    psel = 1'b0; penable = 1'b0;
  endtask

  // One AHB transfer; counts select and strobe cycles until ready
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [2:0] sz, input logic [31:0] wd);
    int i;
    @(negedge clk_sys);
    hsel = 1'b1; htrans = 2'b10; hwrite = wr; haddr = a; hsize = sz;
    @(negedge clk_sys);
    hsel = 1'b0; htrans = 2'b00; hwdata = wd;
    ncs = 0; nc1 = 0; nrd = 0; nw0 = 0; nw1 = 0; noe = 0;
    for (i = 0; i < 100; i++) begin
      if (!sel0_n || !sel1_n) begin
        if (ncs == 0) first_addr = ext_addr;
        ncs++;
      end
      nc1 += int'(!sel1_n); nrd += int'(!rd_n); nw0 += int'(!bws_n[0]); nw1 += int'(!bws_n[1]);
      noe += int'(oe);
      if (hready_out === 1'b1) break;
      ext_ready = (ncs >= rdy_after);
      @(negedge clk_sys);
    end
    if (i == 100) begin
      num_errors++;
      complete_run;
    end
    resp = hresp;
    rdat = hrdata;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    int w;
    {hsel, hwrite, psel, penable, pwrite, pin_en} = '0;
    {haddr, hwdata, htrans, hsize, paddr, pwdata} = '0;
    hready_in = 1'b1; ext_ready = 1'b1; rdy_after = 0; num_errors = 0; comparisons = 0;
    rst = 1'b1;
    repeat (5) @(posedge clk_sys);
    @(negedge clk_sys) rst = 1'b0;
    apb(1'b0, `SMI_OFS_CFG0, 16'h0000); check(prdata, 32'h7F3D);
    apb(1'b0, `SMI_OFS_CFG1, 16'h0000); check(prdata, 32'h0001);
    apb(1'b0, `SMI_OFS_BASE1, 16'h0000); check(prdata, 32'h0000);
    apb(1'b1, `SMI_OFS_RSV0, 16'hFFFF);
    apb(1'b0, `SMI_OFS_RSV0, 16'h0000); check(prdata, 32'h0001);
    ahb(1'b0, 32'h0000_0010, 3'h1, 32'h0); check(ncs, 9);
    // Wait-state sweep over single half-word cycles
    for (w = 0; w < 8; w++) begin
      apb(1'b1, `SMI_OFS_CFG0, 16'h7F21 | 16'(w << 2));
      ahb(1'b1, 32'h0000_0010, 3'h1, 32'h0000_A500 + w);
      check(ncs, w + 2);
      check(nw0, w + 1);
      check(nw1, w + 1);
      check(noe, w + 2);
      ahb(1'b0, 32'h0000_0010, 3'h1, 32'h0);
      check(ncs, w + 2);
      check(nrd, w + 2);
      check(noe, 0);
      check(first_addr, 22'h00_0008);
      check(rdat, {2{16'hA500 + 16'(w)}});
    end
    ahb(1'b1, 32'h0000_0011, 3'h0, 32'h0000_5A00);
    check(nw1, 8);
    check(nw0, 0);
    ahb(1'b0, 32'h0000_0010, 3'h1, 32'h0); check(rdat, 32'h5A07_5A07);
    // Split 32-bit cycles
    apb(1'b1, `SMI_OFS_CFG0, 16'h7F25);
    ahb(1'b1, 32'h0000_0040, 3'h2, 32'h6FF6_DAAD);
    check(ncs, 6);
    check(nw0, 4);
    ahb(1'b0, 32'h0000_0040, 3'h2, 32'h0);
    check(ncs, 6);
    check(rdat, 32'h6FF6_DAAD);
    check(first_addr, 22'h00_0020);
    ahb(1'b0, 32'h0000_0042, 3'h1, 32'h0); check(rdat, 32'h6FF6_6FF6);
    // Region decode
    apb(1'b1, `SMI_OFS_CFG0, 16'h0025);
    apb(1'b1, `SMI_OFS_BASE1, 16'h0200);
    apb(1'b1, `SMI_OFS_CFG1, 16'h0025);
    ahb(1'b0, 32'h0010_0006, 3'h1, 32'h0);
    check(resp, `SMI_HRESP_ERROR);
    check(ncs, 0);
    pin_en = 1'b1;
    ahb(1'b0, 32'h0010_0006, 3'h1, 32'h0);
    check(resp, `SMI_HRESP_OKAY);
    check(nc1, 3);
    check(first_addr, 22'h08_0003);
    ahb(1'b0, 32'h0011_0000, 3'h1, 32'h0); check(resp, `SMI_HRESP_ERROR);
    ahb(1'b0, 32'h0001_0000, 3'h1, 32'h0); check(resp, `SMI_HRESP_ERROR);
    apb(1'b1, `SMI_OFS_CFG1, 16'h0005);
    ahb(1'b0, 32'h0010_0006, 3'h1, 32'h0);
    check(resp, `SMI_HRESP_ERROR);
    check(ncs, 0);
    // Ready-terminated cycles, synchronised then direct
    apb(1'b1, `SMI_OFS_CFG0, 16'h7FE1);
    apb(1'b0, `SMI_OFS_CFG0, 16'h0000); check(prdata, 32'h7FE1);
    rdy_after = 6;
    ahb(1'b0, 32'h0000_0010, 3'h1, 32'h0); check(ncs, 8);
    apb(1'b1, `SMI_OFS_CFG0, 16'h7FB5);
    rdy_after = 9;
    ahb(1'b0, 32'h0000_0010, 3'h1, 32'h0);
    check(ncs, 9);
    check(rdat, 32'h5A07_5A07);
    rdy_after = 0;
    complete_run;
  end
endmodule
`default_nettype wire
